/* File: verif/board_master_model.sv */
// Board reset, strap and SMBus halt-bit master model for the sequencer.
`timescale 1ns/1ps
module board_master_model (
    input wire logic clock,
    input wire logic wakeOut,
    input wire logic wakeOe,
    output logic resetN,
    output logic holdStrap,
    output logic [2:0] modeStraps,
    output logic haltWrite,
    output logic haltValue,
    output logic initDone,
    output logic wakeLevel
);
    logic pullLow;
    // The wake line is open drain with a pull-up, so it is low if either side pulls.
    assign wakeLevel = ~((wakeOe & ~wakeOut) | pullLow);
    initial
    begin
        resetN = 1'b0;
        holdStrap = 1'b0;
        modeStraps = 3'h0;
        haltWrite = 1'b0;
        haltValue = 1'b0;
        initDone = 1'b0;
        pullLow = 1'b0;
    end
    task automatic pullReset();
        @(posedge clock);
        resetN <= 1'b0;
    endtask : pullReset
    task automatic boot(input logic hold, input logic [2:0] mode);
        pullReset();
        holdStrap <= hold;
        modeStraps <= mode;
        repeat (6) @(posedge clock);
        resetN <= 1'b1;
        repeat (4) @(posedge clock);
        // Straps move after release so a design that keeps sampling them is caught.
        holdStrap <= ~hold;
        modeStraps <= ~mode;
    endtask : boot
    task automatic writeHalt(input logic v);
        @(posedge clock);
        haltWrite <= 1'b1;
        haltValue <= v;
        @(posedge clock);
        haltWrite <= 1'b0;
        haltValue <= ~v;
    endtask : writeHalt
    task automatic finishInit();
        @(posedge clock);
        initDone <= 1'b1;
        @(posedge clock);
        initDone <= 1'b0;
    endtask : finishInit
    task automatic pullWake(input logic v);
        @(posedge clock);
        pullLow <= v;
    endtask : pullWake
endmodule : board_master_model

/* File: verif/tb_top.sv */
// Self-checking bench for the reset, halt and boot-mode sequencer.
`timescale 1ns/1ps
module tb_top;
    import reset_halt_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic dirSel = 1'b0;
    logic wakeReq = 1'b0;
    logic rstN, hold, hWr, hVal, initDone, wIn, wOut, wOe, wakeSeen, haltBit;
    logic smbusEnable, regAccessEnable, eepromInitStart, switchRun, modeReserved;
    logic [2:0] mode, sampledMode;
    logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    int fails = 0;
    int n_checks = 0;
    initial forever #4 clock = ~clock;
    board_master_model board (.clock(clock), .wakeOut(wOut), .wakeOe(wOe), .resetN(rstN),
        .holdStrap(hold), .modeStraps(mode), .haltWrite(hWr), .haltValue(hVal),
        .initDone(initDone), .wakeLevel(wIn));
    reset_halt_boot_mode_control DUT (.clock(clock), .sys_rst(sys_rst),
        .fundamental_reset_n(rstN), .reset_hold_request(hold),
        .switch_operating_mode_straps(mode), .haltBitWrite(hWr), .haltBitValue(hVal),
        .wake_direction_select(dirSel), .wakeRequest(wakeReq), .eepromInitDone(initDone),
        .wake_signal_pin_in(wIn), .wake_signal_pin_out(wOut), .wake_signal_pin_oe(wOe),
        .wakeSeen(wakeSeen), .haltBit(haltBit), .smbusEnable(smbusEnable),
        .regAccessEnable(regAccessEnable), .eepromInitStart(eepromInitStart),
        .switchRun(switchRun), .modeReserved(modeReserved), .sampledMode(sampledMode));
    task automatic results();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check
    task automatic waitFor(input string what, input int sel);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clock);
            #1;
            if ((sel == 0 && smbusEnable === 1'b1) || (sel == 1 && switchRun === 1'b1)
                || (sel == 2 && eepromInitStart === 1'b1))
                return;
        end
        fails++;
        $display("unexpected %s: expected 1, seen timeout", what);
        results();
    endtask : waitFor
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic testHalt();
        board.boot(1'b1, MODE_NORMAL);
        waitFor("smbusEnable", 0);
        settle(3);
        check("switchRun", 3'h0, {2'h0, switchRun});
        check("regAccessEnable", 3'h1, {2'h0, regAccessEnable});
        check("haltBit", 3'h1, {2'h0, haltBit});
        check("sampledMode", MODE_NORMAL, sampledMode);
        board.writeHalt(1'b0);
        waitFor("switchRun", 1);
        check("haltBit", 3'h0, {2'h0, haltBit});
        $display("test halt done");
    endtask : testHalt
    task automatic testModes();
        foreach (modes[k])
        begin
            board.boot(1'b0, modes[k]);
            if (modes[k] == MODE_EEPROM)
            begin
                waitFor("eepromInitStart", 2);
                settle(2);
                check("switchRun", 3'h0, {2'h0, switchRun});
                board.finishInit();
            end
            waitFor("switchRun", 1);
            check("sampledMode", modes[k], sampledMode);
            check("modeReserved", {2'h0, modes[k] >= MODE_RSVD_FIRST},
                {2'h0, modeReserved});
            board.pullReset();
            settle(4);
            check("switchRun", 3'h0, {2'h0, switchRun});
            check("smbusEnable", 3'h0, {2'h0, smbusEnable});
        end
        $display("test modes done");
    endtask : testModes
    task automatic testWake();
        // The wake driver is gated off in fundamental reset, so leave it first.
        board.boot(1'b0, MODE_NORMAL);
        @(posedge clock);
        dirSel <= 1'b1;
        wakeReq <= 1'b1;
        settle(3);
        check("wakeOe", 3'h1, {2'h0, wOe});
        check("wakeOut", 3'h0, {2'h0, wOut});
        @(posedge clock);
        dirSel <= 1'b0;
        settle(5);
        check("wakeOe", 3'h0, {2'h0, wOe});
        check("wakeSeen", 3'h0, {2'h0, wakeSeen});
        board.pullWake(1'b1);
        settle(5);
        check("wakeSeen", 3'h1, {2'h0, wakeSeen});
        board.pullWake(1'b0);
        settle(5);
        check("wakeSeen", 3'h0, {2'h0, wakeSeen});
        $display("test wake done");
    endtask : testWake
    initial
    begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        testHalt();
        testModes();
        testWake();
        results();
    end
endmodule : tb_top

/* File: verilog/reset_halt_boot_mode_control.sv */
// Sequencer that leaves fundamental reset, optionally halting for SMBus setup.
`timescale 1ns/1ps
module reset_halt_boot_mode_control (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic fundamental_reset_n,
    input wire logic reset_hold_request,
    input wire logic [reset_halt_pkg::MODE_W-1:0] switch_operating_mode_straps,
    input wire logic haltBitWrite,
    input wire logic haltBitValue,
    input wire logic wake_direction_select,
    input wire logic wakeRequest,
    input wire logic eepromInitDone,
    input wire logic wake_signal_pin_in,
    output logic wake_signal_pin_out,
    output logic wake_signal_pin_oe,
    output logic wakeSeen,
    output logic haltBit,
    output logic smbusEnable,
    output logic regAccessEnable,
    output logic eepromInitStart,
    output logic switchRun,
    output logic modeReserved,
    output logic [reset_halt_pkg::MODE_W-1:0] sampledMode
);
    import reset_halt_pkg::*;

    // Pins from the board are synchronised before any logic reads them.
    logic [1:0] rstSync_ff;
    logic [1:0] holdSync_ff;
    logic [MODE_W-1:0] modeSync0_ff;
    logic [MODE_W-1:0] modeSync1_ff;
    logic [1:0] wakeSync_ff;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rstSync_ff <= 2'h0;
            holdSync_ff <= 2'h0;
            modeSync0_ff <= 3'h0;
            modeSync1_ff <= 3'h0;
            wakeSync_ff <= 2'h3;
        end
        else
        begin
            rstSync_ff <= {rstSync_ff[0], fundamental_reset_n};
            holdSync_ff <= {holdSync_ff[0], reset_hold_request};
            modeSync0_ff <= switch_operating_mode_straps;
            modeSync1_ff <= modeSync0_ff;
            wakeSync_ff <= {wakeSync_ff[0], wake_signal_pin_in};
        end
    end

    wire logic inFundReset = ~rstSync_ff[1];

    function automatic logic isReserved(input logic [MODE_W-1:0] m);
        return m >= MODE_RSVD_FIRST;
    endfunction : isReserved

    seq_state_t state_ff, nxt_state;
    strap_t strap_ff, nxt_strap;
    logic [4:0] procCnt_ff, nxt_procCnt;
    logic haltBit_ff, nxt_haltBit;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_strap = strap_ff;
        nxt_procCnt = procCnt_ff;
        nxt_haltBit = haltBit_ff;
        if (inFundReset)
        begin
            // Straps follow the pins only while reset is asserted.
            nxt_strap.holdRequest = holdSync_ff[1];
            nxt_strap.mode = modeSync1_ff;
            nxt_haltBit = holdSync_ff[1];
            nxt_procCnt = PROC_CNT_INIT;
            nxt_state = ST_FUND_RESET;
        end
        else
        begin
            if (haltBitWrite)
            begin
                nxt_haltBit = haltBitValue;
            end
            case (state_ff)
                ST_FUND_RESET:
                begin
                    nxt_state = ST_PROCEDURE;
                end
                ST_PROCEDURE:
                begin
                    nxt_procCnt = procCnt_ff + 5'h01;
                    if (procCnt_ff == PROC_CNT_LAST)
                    begin
                        // The procedure always runs fully before any halt.
                        if (strap_ff.holdRequest)
                            nxt_state = ST_HALTED;
                        else if (strap_ff.mode == MODE_EEPROM)
                            nxt_state = ST_EEPROM_INIT;
                        else
                            nxt_state = ST_RUN;
                    end
                end
                ST_HALTED:
                begin
                    if (!haltBit_ff)
                    begin
                        if (strap_ff.mode == MODE_EEPROM)
                            nxt_state = ST_EEPROM_INIT;
                        else
                            nxt_state = ST_RUN;
                    end
                end
                ST_EEPROM_INIT:
                begin
                    if (eepromInitDone)
                        nxt_state = ST_RUN;
                end
                ST_RUN:
                begin
                    nxt_state = ST_RUN;
                end
                default:
                begin
                    nxt_state = ST_FUND_RESET;
                end
            endcase
        end
    end

    logic smbus_ff, regAcc_ff, eeStart_ff, run_ff, rsvd_ff, wakeSeen_ff;
    wake_drive_t wake_ff, nxt_wake;
    logic nxt_smbus, nxt_regAcc, nxt_eeStart, nxt_run, nxt_rsvd, nxt_wakeSeen;

    always_comb
    begin
        // SMBus ports run in every state after the procedure, halt included.
        nxt_smbus = (nxt_state == ST_HALTED) || (nxt_state == ST_EEPROM_INIT)
            || (nxt_state == ST_RUN);
        nxt_regAcc = (nxt_state == ST_HALTED) || (nxt_state == ST_RUN);
        nxt_eeStart = (state_ff != ST_EEPROM_INIT) && (nxt_state == ST_EEPROM_INIT);
        nxt_run = nxt_state == ST_RUN;
        // Open-drain: only ever pull low, never drive high.
        nxt_wake.out = 1'b0;
        nxt_wake.oe = wake_direction_select && wakeRequest && !inFundReset;
        nxt_rsvd = isReserved(nxt_strap.mode);
        // Input direction reports a low wake level from outside.
        nxt_wakeSeen = !wake_direction_select && !wakeSync_ff[1];
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_FUND_RESET;
            strap_ff <= '0;
            procCnt_ff <= PROC_CNT_INIT;
            haltBit_ff <= 1'b0;
            smbus_ff <= 1'b0;
            regAcc_ff <= 1'b0;
            eeStart_ff <= 1'b0;
            run_ff <= 1'b0;
            rsvd_ff <= 1'b0;
            wake_ff <= '0;
            wakeSeen_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            strap_ff <= nxt_strap;
            procCnt_ff <= nxt_procCnt;
            haltBit_ff <= nxt_haltBit;
            smbus_ff <= nxt_smbus;
            regAcc_ff <= nxt_regAcc;
            eeStart_ff <= nxt_eeStart;
            run_ff <= nxt_run;
            rsvd_ff <= nxt_rsvd;
            wake_ff <= nxt_wake;
            wakeSeen_ff <= nxt_wakeSeen;
        end
    end

    assign wake_signal_pin_out = wake_ff.out;
    assign wake_signal_pin_oe = wake_ff.oe;
    assign wakeSeen = wakeSeen_ff;
    assign haltBit = haltBit_ff;
    assign smbusEnable = smbus_ff;
    assign regAccessEnable = regAcc_ff;
    assign eepromInitStart = eeStart_ff;
    assign switchRun = run_ff;
    assign modeReserved = rsvd_ff;
    assign sampledMode = strap_ff.mode;

    property p_halt_after_proc;
        @(posedge clock) disable iff (sys_rst)
        (state_ff == ST_PROCEDURE && procCnt_ff == PROC_CNT_LAST && !inFundReset
            && strap_ff.holdRequest) |=> (state_ff == ST_HALTED) && !switchRun;
    endproperty
    a_halt_after_proc: assert property (p_halt_after_proc) else $error("no halt");

    property p_smbus_halted;
        @(posedge clock) disable iff (sys_rst)
        (state_ff == ST_HALTED) |-> smbusEnable && regAccessEnable;
    endproperty
    a_smbus_halted: assert property (p_smbus_halted) else $error("smbus off");

    property p_regacc;
        @(posedge clock) disable iff (sys_rst)
        // Register access is open exactly in the halted and running states.
        regAccessEnable == ((state_ff == ST_HALTED) || (state_ff == ST_RUN));
    endproperty
    a_regacc: assert property (p_regacc) else $error("bad reg access");

    property p_release;
        @(posedge clock) disable iff (sys_rst)
        (state_ff == ST_HALTED && !haltBit_ff && !inFundReset) |=> state_ff != ST_HALTED;
    endproperty
    a_release: assert property (p_release) else $error("halt not released");

    property p_eeprom;
        @(posedge clock) disable iff (sys_rst)
        eepromInitStart |-> strap_ff.mode == MODE_EEPROM;
    endproperty
    a_eeprom: assert property (p_eeprom) else $error("bad eeprom start");

    property p_wake;
        @(posedge clock) disable iff (sys_rst)
        wake_signal_pin_oe |-> $past(wake_direction_select) && !wake_signal_pin_out;
    endproperty
    a_wake: assert property (p_wake) else $error("wake driven wrongly");

    property p_reset;
        @(posedge clock) disable iff (sys_rst)
        inFundReset |=> state_ff == ST_FUND_RESET ##1 !switchRun;
    endproperty
    a_reset: assert property (p_reset) else $error("reset ignored");

    property p_strap_hold;
        @(posedge clock) disable iff (sys_rst)
        !inFundReset && !$past(inFundReset) |-> $stable(strap_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

    c_halted: cover property (@(posedge clock) state_ff == ST_HALTED ##1 state_ff == ST_RUN);
    c_eeprom: cover property (@(posedge clock) eepromInitStart);
    c_run: cover property (@(posedge clock) switchRun);
endmodule : reset_halt_boot_mode_control

/* File: verilog/reset_halt_pkg.sv */
// Package with types and constants for the reset, halt and boot-mode sequencer.
package reset_halt_pkg;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_EEPROM = 3'h1;
    localparam logic [2:0] MODE_RSVD_FIRST = 3'h2;
    // Cycles spent in the internal reset procedure after the fundamental reset releases.
    localparam int RESET_PROC_CYCLES = 16;
    localparam logic [4:0] PROC_CNT_INIT = 5'h00;
    localparam logic [4:0] PROC_CNT_LAST = 5'(RESET_PROC_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_FUND_RESET = 3'b000,
        ST_PROCEDURE = 3'b001,
        ST_HALTED = 3'b010,
        ST_EEPROM_INIT = 3'b011,
        ST_RUN = 3'b100
    } seq_state_t;

    // Sampled straps, held from one fundamental reset to the next.
    typedef struct packed {
        logic holdRequest;
        logic [2:0] mode;
    } strap_t;

    // Driven half of the open-drain wake pin: output level and output enable.
    typedef struct packed {
        logic out;
        logic oe;
    } wake_drive_t;
endpackage : reset_halt_pkg
